// ===== sbf_baud_gen.sv
// Two-stage bit-rate divider: prescaler then power-of-two rate divider
module sbf_baud_gen
    import sbf_pkg::*;
#(
    parameter int CODE_W = SBF_CODE_W
)
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              run,
    input  wire logic [CODE_W-1:0] prescale_code,
    input  wire logic [CODE_W-1:0] rate_divide_code,
    output logic                   bit_tick
);
    typedef struct packed {
        logic [CODE_W-1:0] pre_cnt;
        logic [8:0]        rate_cnt;
        logic              tick;
    } sbf_bg_state_t;

    sbf_bg_state_t st_r;
    sbf_bg_state_t st_nxt;
    logic          pre_tick;
    logic [8:0]    rate_div;

    // rate ratios
    // Half the divisor, 1..128, gives one tick per SCK edge
    assign rate_div = 9'h001 << rate_divide_code;

    // prescale divisor
    // Prescaler counts bus clocks up to the code, divisor is code plus one
    assign pre_tick = (st_r.pre_cnt == prescale_code);

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!run)
        begin
            st_nxt.pre_cnt  = '0;
            st_nxt.rate_cnt = '0;
        end
        else if (pre_tick)
        begin
            st_nxt.pre_cnt = '0;
            if (st_r.rate_cnt + 9'h001 >= rate_div)
            begin
                st_nxt.rate_cnt = '0;
                st_nxt.tick     = 1'b1;
            end
            else
                st_nxt.rate_cnt = st_r.rate_cnt + 9'h001;
        end
        else
            st_nxt.pre_cnt = st_r.pre_cnt + CODE_W'(1);
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign bit_tick = st_r.tick;

    // Tick is a single-cycle pulse unless both prescale and rate codes are zero
    AST_TICK_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
        st_r.tick |=> !st_r.tick || (prescale_code == '0
        && rate_divide_code == '0))
        else $error("bit tick held longer than expected");

endmodule // sbf_baud_gen

// ===== sbf_mode_fault.sv
// Mode-fault detector: watches slave select while acting as master
module sbf_mode_fault
    import sbf_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic master_select,
    input  wire logic fault_detect_enable,
    input  wire logic select_output_enable,
    input  wire logic ss_in_n,
    output logic      fault_event
);
    typedef struct packed {
        logic ev;
    } sbf_mf_state_t;

    sbf_mf_state_t st_r;
    sbf_mf_state_t st_nxt;
    logic          armed;

    assign armed = master_select && fault_detect_enable
                   && !select_output_enable;

    always_comb
    begin
        st_nxt      = st_r;
        // Level, not edge: a select held low keeps the fault asserted
        st_nxt.ev   = armed && !ss_in_n;
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            st_r <= '{ev: 1'b0};
        else
            st_r <= st_nxt;
    end

    assign fault_event = st_r.ev;

    AST_MF_GATED: assert property (@(posedge sys_clk) disable iff (rst)
        st_r.ev |-> $past(armed) && !$past(ss_in_n))
        else $error("mode fault event without armed master");

endmodule // sbf_mode_fault

// ===== sbf_pkg.sv
// Package: register map, field layout and types of the baud/status block
package sbf_pkg;

    // Register byte addresses on the APB
    localparam logic [7:0] SBF_ADDR_CTRL1  = 8'h00;
    localparam logic [7:0] SBF_ADDR_CTRL2  = 8'h04;
    localparam logic [7:0] SBF_ADDR_BAUD   = 8'h08;
    localparam logic [7:0] SBF_ADDR_STATUS = 8'h0c;
    localparam logic [7:0] SBF_ADDR_DATA   = 8'h10;
    localparam logic [7:0] SBF_ADDR_XFER   = 8'h14;

    // Control register 1 bit positions
    localparam int SBF_C1_RXIE = 7;
    localparam int SBF_C1_EN   = 6;
    localparam int SBF_C1_TXIE = 5;
    localparam int SBF_C1_MASTER_SELECT = 4;
    localparam int SBF_C1_SELECT_OUTPUT_ENABLE = 1;
    // Control register 2 bit positions
    localparam int SBF_C2_FDEN = 4;

    // Baud register fields
    localparam int SBF_PRE_LSB  = 4;
    localparam int SBF_RATE_LSB = 0;
    localparam int SBF_CODE_W   = 3;

    // Status register bit positions
    localparam int SBF_ST_RXF  = 7;
    localparam int SBF_ST_TXE  = 5;
    localparam int SBF_ST_MASTER_FAULT_FLAG = 4;

    // Reset values
    localparam logic [7:0] SBF_C1_RST   = 8'h04;
    localparam logic [7:0] SBF_C2_RST   = 8'h00;
    localparam logic [7:0] SBF_BAUD_RST = 8'h00;

    // Bits per serial transfer
    localparam int SBF_BITS = 8;

    // Unmapped-address answer
    localparam logic [31:0] SBF_RD_ZERO = 32'h0000_0000;

    // APB request as seen by the slave
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } sbf_apb_req_t;

    // Flags shared between files
    typedef struct packed {
        logic rx_full_flag;
        logic tx_empty_flag;
        logic master_fault_flag;
    } sbf_flags_t;

endpackage

// ===== sbf_slave_model.sv
// Behavioural serial slave that echoes the previous frame back
module sbf_slave_model
#(
    parameter logic [7:0] SEED = 8'h5a
)
(
    input  wire logic       rst,
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh;
    logic [7:0] rx;
    // Start values: reset is high from time zero, so no edge would load them
    logic [7:0] echo = SEED;
    int         cnt  = 0;
    assign rx_byte = echo;
    // First bit straight from the echo byte, so it is valid before edge one
    assign miso = (cnt == 0) ? echo[7] : sh[7];
    // Sample on rising clock
    always @(posedge sck)
        rx <= {rx[6:0], mosi};
    // Shift on falling clock, echo byte taken after its first bit
    always @(negedge sck or posedge rst)
    begin
        if (rst)
        begin
            cnt  <= 0;
            echo <= SEED;
        end
        else
        begin
            sh  <= (cnt == 0) ? echo << 1 : sh << 1;
            cnt <= (cnt == 7) ? 0 : cnt + 1;
            if (cnt == 7)
                echo <= rx;
        end
    end
endmodule // sbf_slave_model

// ===== sbf_spi_core.sv
// Serial interface bit-rate and status flag core with APB register slave
//
// Contract
// - Prescale code at bits 6:4 divides bus clock by code plus one.
// - Prescaler runs on bus clock and feeds the rate divider.
// - Rate code at bits 2:0 divides by 2 up to 256.
// - Rate divider output is master bit clock; rate is product of both.
// - Bit-rate register readable and writable at any time.
// - Status bits 6,3,2,1,0 read zero; status writes do nothing.
// - Receive-full flag at bit 7 sets when a transfer completes.
// - Receive-full clears after status read seeing it, then data read.
// - Transmit-empty flag at bit 5 shows transmit buffer has room.
// - Transmit-empty clears on status read seeing it, then data write.
// - Data write without prior status read of transmit-empty is ignored.
// - Interrupt when transmit-empty and transmit interrupt enable set.
// - Transmit-empty sets when buffer byte moves to shifter.
// - Idle interface: byte moves at once, flag back within two cycles; the code moves it only with master select set.
// - End of transfer loads waiting byte and sets transmit-empty.
// - No waiting byte: flag stays set, nothing moves.
// - Mode-fault flag at bit 4 sets when master sees select low.
// - Mode fault only with master, fault enable, no select output.
// - Mode fault clears on status read seeing it, then control-1 write.
// - Module disable halts transfer, empties buffers, resets flags; the mode-fault flag is kept.
// - Receive interrupt enable raises interrupt on receive-full or fault.
// - Transfer ending with unread receive buffer drops the new byte.
//
// Register access over APB and the register addresses were decided locally.
module sbf_spi_core
    import sbf_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ss_in_n,
    input  wire logic        miso_in,
    output logic             mosi_out,
    output logic             sck_out,
    output logic             irq_out
);
    typedef enum logic [1:0] {
        SH_IDLE,
        SH_LOAD,
        SH_SHIFT
    } sbf_sh_t;

    typedef struct packed {
        logic [7:0]  ctrl1;
        logic [7:0]  ctrl2;
        logic [7:0]  baud;
        sbf_flags_t  flags;
        logic        rxf_seen;
        logic        txe_seen;
        logic        mf_seen;
        logic [7:0]  tx_buf;
        logic        tx_full;
        logic [7:0]  rx_buf;
        logic [7:0]  shreg;
        sbf_sh_t     sh;
        logic [4:0]  edge_cnt;
        logic        sck;
        logic        mosi;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        irq;
    } sbf_core_state_t;

    sbf_core_state_t st_r;
    sbf_core_state_t st_nxt;
    sbf_apb_req_t    req;
    logic            bit_tick;
    logic            fault_event;
    logic            enabled;
    logic            setup;
    logic            wr;
    logic            rd;
    logic [7:0]      status_byte;

    assign req     = '{psel: psel, penable: penable, pwrite: pwrite,
                       paddr: paddr, pwdata: pwdata};
    assign enabled = st_r.ctrl1[SBF_C1_EN];
    // Register access decoded in the setup cycle, answered next cycle
    assign setup   = req.psel && !req.penable;
    assign wr      = setup && req.pwrite;
    assign rd      = setup && !req.pwrite;

    assign status_byte = {st_r.flags.rx_full_flag, 1'b0,
                          st_r.flags.tx_empty_flag,
                          st_r.flags.master_fault_flag, 4'h0};

    // Address hit helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    sbf_baud_gen u_baud (
        .sys_clk          (sys_clk),
        .rst              (rst),
        .run              (enabled && st_r.sh == SH_SHIFT),
        .prescale_code    (st_r.baud[SBF_PRE_LSB +: SBF_CODE_W]),
        .rate_divide_code (st_r.baud[SBF_RATE_LSB +: SBF_CODE_W]),
        .bit_tick         (bit_tick)
    );

    sbf_mode_fault u_fault (
        .sys_clk              (sys_clk),
        .rst                  (rst),
        .master_select        (enabled && st_r.ctrl1[SBF_C1_MASTER_SELECT]),
        .fault_detect_enable  (st_r.ctrl2[SBF_C2_FDEN]),
        .select_output_enable (st_r.ctrl1[SBF_C1_SELECT_OUTPUT_ENABLE]),
        .ss_in_n              (ss_in_n),
        .fault_event          (fault_event)
    );

    // Next-state logic: bus slave, buffers, shifter, flags
    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.ready = setup;
        st_nxt.slverr = 1'b0;

        // Bus reads: data captured at setup, presented in access cycle
        if (rd)
        begin
            st_nxt.rdata = SBF_RD_ZERO;
            if (hit(req.paddr, SBF_ADDR_CTRL1))
                st_nxt.rdata[7:0] = st_r.ctrl1;
            else if (hit(req.paddr, SBF_ADDR_CTRL2))
                st_nxt.rdata[7:0] = st_r.ctrl2;
            else if (hit(req.paddr, SBF_ADDR_BAUD))
                st_nxt.rdata[7:0] = st_r.baud;
            else if (hit(req.paddr, SBF_ADDR_STATUS))
            begin
                st_nxt.rdata[7:0] = status_byte;
                st_nxt.rxf_seen = st_r.flags.rx_full_flag;
                st_nxt.txe_seen = st_r.flags.tx_empty_flag;
                st_nxt.mf_seen  = st_r.flags.master_fault_flag;
            end
            else if (hit(req.paddr, SBF_ADDR_DATA))
            begin
                st_nxt.rdata[7:0] = st_r.rx_buf;
                if (st_r.rxf_seen)
                begin
                    st_nxt.flags.rx_full_flag = 1'b0;
                    st_nxt.rxf_seen = 1'b0;
                end
            end
            else if (hit(req.paddr, SBF_ADDR_XFER))
                st_nxt.rdata[7:0] = {7'h00, st_r.sh != SH_IDLE};
            else
                st_nxt.slverr = 1'b1;
        end

        // Bus writes; status and unknown addresses change nothing
        if (wr)
        begin
            if (hit(req.paddr, SBF_ADDR_CTRL1))
            begin
                st_nxt.ctrl1 = req.pwdata[7:0];
                if (st_r.mf_seen)
                begin
                    st_nxt.flags.master_fault_flag = 1'b0;
                    st_nxt.mf_seen = 1'b0;
                end
            end
            else if (hit(req.paddr, SBF_ADDR_CTRL2))
                st_nxt.ctrl2 = req.pwdata[7:0];
            else if (hit(req.paddr, SBF_ADDR_BAUD))
                st_nxt.baud = req.pwdata[7:0];
            else if (hit(req.paddr, SBF_ADDR_DATA))
            begin
                if (st_r.txe_seen && st_r.flags.tx_empty_flag && enabled)
                begin
                    st_nxt.tx_buf  = req.pwdata[7:0];
                    st_nxt.tx_full = 1'b1;
                    st_nxt.flags.tx_empty_flag = 1'b0;
                    st_nxt.txe_seen = 1'b0;
                end
            end
            else if (!hit(req.paddr, SBF_ADDR_STATUS)
                     && !hit(req.paddr, SBF_ADDR_XFER))
                st_nxt.slverr = 1'b1;
        end

        // Shift engine, master only, clocked by the rate divider
        case (st_r.sh)
            SH_IDLE:
            begin
                if (st_r.tx_full && enabled && st_r.ctrl1[SBF_C1_MASTER_SELECT])
                    st_nxt.sh = SH_LOAD;
            end
            SH_LOAD:
            begin
                st_nxt.shreg    = st_r.tx_buf;
                st_nxt.mosi     = st_r.tx_buf[SBF_BITS-1];
                st_nxt.tx_full  = 1'b0;
                st_nxt.flags.tx_empty_flag = 1'b1;
                st_nxt.edge_cnt = '0;
                st_nxt.sh       = SH_SHIFT;
            end
            SH_SHIFT:
            begin
                if (bit_tick)
                begin
                    st_nxt.sck      = !st_r.sck;
                    st_nxt.edge_cnt = st_r.edge_cnt + 5'h01;
                    if (!st_r.sck)
                        st_nxt.shreg = {st_r.shreg[SBF_BITS-2:0], miso_in};
                    else
                        st_nxt.mosi = st_r.shreg[SBF_BITS-1];
                    if (st_r.edge_cnt == 5'(2 * SBF_BITS - 1))
                    begin
                        // drop byte on overrun
                        // A data read clearing in this cycle frees it
                        if (!st_nxt.flags.rx_full_flag)
                        begin
                            st_nxt.rx_buf = st_nxt.shreg;
                            st_nxt.flags.rx_full_flag = 1'b1;
                        end
                        st_nxt.sh = st_r.tx_full ? SH_LOAD : SH_IDLE;
                    end
                end
            end
            default:
                st_nxt.sh = SH_IDLE;
        endcase

        // fault flag set wins over clear
        if (fault_event)
            st_nxt.flags.master_fault_flag = 1'b1;

        if (!st_nxt.ctrl1[SBF_C1_EN])
        begin
            st_nxt.sh       = SH_IDLE;
            st_nxt.tx_full  = 1'b0;
            st_nxt.sck      = 1'b0;
            st_nxt.edge_cnt = '0;
            st_nxt.flags.rx_full_flag  = 1'b0;
            st_nxt.flags.tx_empty_flag = 1'b1;
        end

        // transmit interrupt, receive and fault interrupt
        st_nxt.irq = (st_nxt.flags.tx_empty_flag
                      && st_nxt.ctrl1[SBF_C1_TXIE])
                     || ((st_nxt.flags.rx_full_flag
                          || st_nxt.flags.master_fault_flag)
                         && st_nxt.ctrl1[SBF_C1_RXIE]);
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_r       <= '0;
            st_r.ctrl1 <= SBF_C1_RST;
            st_r.ctrl2 <= SBF_C2_RST;
            st_r.baud  <= SBF_BAUD_RST;
            st_r.flags <= '{rx_full_flag: 1'b0, tx_empty_flag: 1'b1,
                            master_fault_flag: 1'b0};
            st_r.sh    <= SH_IDLE;
        end
        else
            st_r <= st_nxt;
    end

    assign prdata   = st_r.rdata;
    assign pready   = st_r.ready;
    assign pslverr  = st_r.slverr;
    assign mosi_out = st_r.mosi;
    assign sck_out  = st_r.sck;
    assign irq_out  = st_r.irq;

    AST_TXE_BACK: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.sh == SH_IDLE && st_nxt.sh == SH_LOAD) |-> ##2
        st_r.flags.tx_empty_flag)
        else $error("transmit-empty not back within two cycles");
    AST_TXE_CLR: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(st_r.flags.tx_empty_flag) |-> $past(st_r.txe_seen)
        && $past(wr))
        else $error("transmit-empty cleared without status read");
    AST_RXF_CLR: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(st_r.flags.rx_full_flag) && enabled |->
        $past(st_r.rxf_seen) && $past(rd))
        else $error("receive-full cleared without proper reads");
    AST_MF_CLR: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(st_r.flags.master_fault_flag) |-> $past(st_r.mf_seen)
        && $past(wr))
        else $error("mode fault cleared without control write");
    AST_MF_SET: assert property (@(posedge sys_clk) disable iff (rst)
        fault_event |=> st_r.flags.master_fault_flag)
        else $error("mode fault event lost");
    AST_IRQ: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.flags.tx_empty_flag && st_r.ctrl1[SBF_C1_TXIE]) |->
        irq_out)
        else $error("transmit interrupt missing");
    AST_RXIRQ: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.flags.master_fault_flag && st_r.ctrl1[SBF_C1_RXIE]) |->
        irq_out)
        else $error("fault interrupt missing");
    AST_DISABLE: assert property (@(posedge sys_clk) disable iff (rst)
        !enabled |-> st_r.flags.tx_empty_flag && !st_r.tx_full
        && st_r.sh == SH_IDLE)
        else $error("disabled module not emptied");
    AST_STATUS_RO: assert property (@(posedge sys_clk) disable iff (rst)
        (rd && hit(req.paddr, SBF_ADDR_STATUS)) |=>
        prdata[6] == 1'b0 && prdata[3:0] == 4'h0)
        else $error("unimplemented status bits not zero");
    AST_TXE_ROOM: assert property (@(posedge sys_clk) disable iff (rst)
        st_r.flags.tx_empty_flag == !st_r.tx_full)
        else $error("transmit-empty does not match buffer room");
    AST_RX_DROP: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.flags.rx_full_flag && !rd) |=> $stable(st_r.rx_buf))
        else $error("unread receive byte overwritten");
    AST_TX_IGNORE: assert property (@(posedge sys_clk) disable iff (rst)
        (wr && hit(req.paddr, SBF_ADDR_DATA) && !st_r.txe_seen) |=>
        $stable(st_r.tx_buf))
        else $error("data write taken without status read");

endmodule // sbf_spi_core

// ===== spi_baud_and_status_flags_bench.sv
// Self-checking bench of the bit-rate and status flag core
module spi_baud_and_status_flags_bench
    import sbf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] EN   = 32'h1 << SBF_C1_EN;
    localparam logic [31:0] MS   = 32'h1 << SBF_C1_MASTER_SELECT;
    localparam logic [31:0] TXE  = 32'h1 << SBF_ST_TXE;
    localparam logic [31:0] RXF  = 32'h1 << SBF_ST_RXF;
    localparam logic [31:0] MASTER_FAULT_FLAG = 32'h1 << SBF_ST_MASTER_FAULT_FLAG;
    localparam logic [7:0]  SEED = 8'h5a;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ss_in_n = 1'b1;
    logic        miso_in;
    logic        mosi_out;
    logic        sck_out;
    logic        irq_out;
    logic [7:0]  rx_byte;
    logic [31:0] q;
    logic        err;
    logic [31:0] ctl;
    logic [31:0] bv;
    logic [31:0] b1;
    logic [31:0] b2;
    logic        sck_q = 1'b0;
    int          sck_cnt = 0;
    int          sck_gap = 0;
    int          fails = 0;
    int          n_compared = 0;
    int          pre;
    int          rate;

    always #5 sys_clk = ~sys_clk;

    sbf_spi_core sbf_spi_core_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ss_in_n(ss_in_n), .miso_in(miso_in), .mosi_out(mosi_out),
        .sck_out(sck_out), .irq_out(irq_out));
    sbf_slave_model #(.SEED(SEED)) sbf_slave_model_i (.rst(rst),
        .sck(sck_out), .mosi(mosi_out), .miso(miso_in), .rx_byte(rx_byte));

    // Cycles between serial clock edges, compared with the divider setting
    always @(posedge sys_clk)
    begin
        sck_q <= sck_out;
        sck_cnt <= (sck_out !== sck_q) ? 1 : sck_cnt + 1;
        if (sck_out !== sck_q)
            sck_gap <= sck_cnt;
    end

    task automatic summarize;
        if (fails == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; the wait on pready is bounded
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            fails++;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // Poll the busy word until the link has gone quiet
    task automatic wait_idle;
        int n;
        n = 0;
        do
        begin
            rd(SBF_ADDR_XFER);
            n++;
        end
        while (q[0] !== 1'b0 && n < 2000);
        if (n >= 2000)
            fails++;
    endtask

    // Main sequence
    initial
    begin
        void'($urandom(32'hdca3));
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd(SBF_ADDR_STATUS);
        chk("status", TXE, q);
        wr(SBF_ADDR_STATUS, 32'hff);
        rd(SBF_ADDR_STATUS);
        chk("status", TXE, q);
        rd(8'h18);
        chk("pslverr", 32'h1, err);
        pre = $urandom_range(7, 1);
        rate = $urandom_range(2, 0);
        bv = 32'((pre << SBF_PRE_LSB) | rate);
        wr(SBF_ADDR_BAUD, bv);
        rd(SBF_ADDR_BAUD);
        chk("baud", bv, q);
        b1 = $urandom & 32'hff;
        b2 = $urandom & 32'hff;
        // Second data write lacks a status read and must vanish
        wr(SBF_ADDR_CTRL1, EN | MS);
        rd(SBF_ADDR_STATUS);
        wr(SBF_ADDR_DATA, b1);
        wr(SBF_ADDR_DATA, b1 ^ 32'hff);
        rd(SBF_ADDR_STATUS);
        chk("status", TXE, q);
        wr(SBF_ADDR_DATA, b2);
        rd(SBF_ADDR_STATUS);
        chk("status", 32'h0, q);
        wait_idle();
        rd(SBF_ADDR_STATUS);
        chk("status", RXF | TXE, q);
        chk("slave byte", b2, {24'h0, rx_byte});
        chk("sck half", (pre + 1) << rate, sck_gap);
        rd(SBF_ADDR_DATA);
        chk("data", {24'h0, SEED}, q);
        rd(SBF_ADDR_STATUS);
        chk("status", TXE, q);
        // Fill the receive side, then check both interrupt sources
        rd(SBF_ADDR_STATUS);
        wr(SBF_ADDR_DATA, b1);
        wait_idle();
        wr(SBF_ADDR_CTRL1, EN | MS | 32'h80);
        rd(SBF_ADDR_STATUS);
        chk("irq", 32'h1, irq_out);
        wr(SBF_ADDR_CTRL1, EN | MS | 32'h20);
        rd(SBF_ADDR_STATUS);
        chk("irq", 32'h1, irq_out);
        // Disable in mid-transfer with a full receive buffer
        wr(SBF_ADDR_DATA, b2);
        wr(SBF_ADDR_CTRL1, 32'h0);
        rd(SBF_ADDR_STATUS);
        chk("status", TXE, q);
        rd(SBF_ADDR_XFER);
        chk("busy", 32'h0, q);
        // Every master, fault-enable and select-output setting
        for (int i = 0; i < 8; i++)
        begin
            wr(SBF_ADDR_CTRL2, i[1] ? 32'h1 << SBF_C2_FDEN : 32'h0);
            ctl = 32'h80 | EN | (i[2] ? MS : 32'h0) | (i[0] ? 32'h2 : 32'h0);
            wr(SBF_ADDR_CTRL1, ctl);
            @(posedge sys_clk);
            ss_in_n <= 1'b0;
            repeat (3) @(posedge sys_clk);
            ss_in_n <= 1'b1;
            rd(SBF_ADDR_STATUS);
            chk("status", TXE | ((i == 6) ? MASTER_FAULT_FLAG : 32'h0), q);
            chk("irq", {31'h0, i == 6}, irq_out);
            wr(SBF_ADDR_CTRL1, ctl);
            rd(SBF_ADDR_STATUS);
            chk("status", TXE, q);
        end
        summarize();
    end

    // Watchdog far beyond the few thousand cycles the tests need
    initial
    begin
        #400000;
        fails++;
        summarize();
    end
endmodule // spi_baud_and_status_flags_bench
